// File: gbtrx_chan_model.sv
// Behavioural pair of receiver front ends that feeds the receive logic
`timescale 1ns/100ps

module gbtrx_chan_model
  import gbtrx_pkg::*;
(
  input  wire logic [2:0] mode,  // 0 dead,1 guard,2 trip,3 crossed,4-7 fault
  input  wire logic       fch,   // Channel that carries the fault flag
  input  wire logic       boost, // Trip level reads boosted
  output gbtrx_chan_s [1:0] ch   // 0 lower A, 1 upper B
);
  // Faults ride on a guard tone so that only the flag itself is abnormal
  always_comb begin
    ch = '0;
    for (int i = 0; i < 2; i++) begin
      ch[i].guard   = (mode == 3'h1) || mode[2] || (mode == 3'h3 && i == 0);
      ch[i].trip    = (mode == 3'h2) || (mode == 3'h3 && i == 1);
      ch[i].boosted = boost && (mode == 3'h2);
    end
    ch[fch].win_hi = (mode == 3'h4);
    ch[fch].win_lo = (mode == 3'h5);
    ch[fch].agc_hi = (mode == 3'h6);
    ch[fch].agc_lo = (mode == 3'h7);
  end
endmodule // gbtrx_chan_model

// File: gbtrx_defines.svh
// Constants for the guard-before-trip receive logic: offsets, fields, times
`ifndef GBTRX_DEFINES_SVH
`define GBTRX_DEFINES_SVH

// Default system clock rate in Hz
`define GBTRX_CLK_HZ         40000000
// Qualification time in ms (guard, abnormal, absence)
`define GBTRX_QUAL_MS        100
// Continuous block time before the alarm relay drops, in ms
`define GBTRX_ALARM_MS       2000
// Longest trip-hold time in ms
`define GBTRX_HOLD_MAX_MS    8'hFA

// APB register word indices; the byte address is four times the index
`define GBTRX_OFS_CTRL       6'h00
`define GBTRX_OFS_HOLD       6'h01
`define GBTRX_OFS_LIVE       6'h02
`define GBTRX_OFS_ISTAT      6'h03
`define GBTRX_OFS_IMASK      6'h04

// Control register fields
`define GBTRX_CTRL_PERM      0
`define GBTRX_CTRL_BOOST     1
`define GBTRX_CTRL_HOLD_EN   2

// Interrupt status and mask fields
`define GBTRX_EV_TRIP        0
`define GBTRX_EV_BLOCK       1
`define GBTRX_EV_ALARM       2
`define GBTRX_EV_AGC         3

// Reset values
`define GBTRX_CTRL_RST       3'h0
`define GBTRX_HOLD_RST       8'h00
`define GBTRX_IMASK_RST      4'h0

`endif

// File: gbtrx_pkg.sv
// Types shared by the guard-before-trip receive logic
package gbtrx_pkg;

  // One receiver channel as seen from the detector card
  typedef struct packed {
    logic guard;    // Discriminator below the guard threshold
    logic trip;     // Discriminator above the trip threshold
    logic win_hi;   // Tone level crossed the upper window set point
    logic win_lo;   // Tone level crossed the lower window set point
    logic agc_hi;   // Gain-control voltage above its high limit
    logic agc_lo;   // Gain-control voltage below its low limit
    logic boosted;  // Received level reads as trip-boosted
  } gbtrx_chan_s;

  // Decision flags of one cycle, also shown on the live register
  typedef struct packed {
    logic agc_lamp;
    logic alarm;
    logic trip_out;
    logic armed;
    logic inhibit;
    logic latch;
    logic block;
    logic trip_st;
    logic guard_st;
  } gbtrx_live_s;

endpackage

// File: gbtrx_tb.sv
// Self-checking bench for the guard-before-trip receive logic
`timescale 1ns/100ps
`include "gbtrx_defines.svh"

module testbench
  import gbtrx_pkg::*;
;
  // Short counts keep the run brief; expectations derive from these
  localparam int MS    = 4;
  localparam int QUAL  = 20;
  localparam int ALARM = 100;

  logic              mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              trip_out, trip_buf, block_relay, alarm_relay;
  logic              agc_lamp, guard_lamp, irq, err, fch, boost;
  logic [2:0]        mode;
  gbtrx_chan_s [1:0] ch_in;
  int                seed, num_errors, check_count, h;
  logic [2:0]        fl [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};

  gbtrx_top #(.CLK_HZ(4000), .MS_CYC(MS), .QUAL_CYC(QUAL),
    .ALARM_CYC(ALARM)) u_gbtrx_top (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ch_in(ch_in),
    .trip_out(trip_out), .trip_buf(trip_buf), .block_relay(block_relay),
    .alarm_relay(alarm_relay), .agc_lamp(agc_lamp),
    .guard_lamp(guard_lamp), .irq(irq));

  gbtrx_chan_model u_gbtrx_chan_model (
    .mode(mode), .fch(fch), .boost(boost), .ch(ch_in));

  // Clock at 40 MHz
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  function automatic logic [7:0] ba(input logic [5:0] i);
    ba = {i, 2'b00};
  endfunction

  // Hold time saturates at its documented ceiling
  function automatic logic [31:0] exp_hold(input int v);
    exp_hold = (v > 250) ? 32'hFA : 32'(v);
  endfunction

  function automatic logic pick(input int s);
    case (s)
      0: pick = trip_out;
      1: pick = block_relay;
      default: pick = alarm_relay;
    endcase
  endfunction

  // Bounded wait; a timeout shows up as a failed comparison
  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk($sformatf("output %0d level", s), pick(s), v);
    if (pick(s) !== v)
      end_sim;
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk("apb ready", 32'h0, 32'h1);
      end_sim;
    end
  endtask

  // Hang guard
  initial begin
    tick(20000);
    num_errors++;
    end_sim;
  end

  // Main sequence
  initial begin
    seed = 16084;
    num_errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode = 3'h0;
    fch = 1'b0;
    boost = 1'b0;
    tick(4);
    rst_n <= 1'b1;
    chk("trip at reset", trip_out, 1'b0);
    chk("block relay at reset", block_relay, 1'b0);
    chk("alarm relay at reset", alarm_relay, 1'b1);
    tick(ALARM - 5);
    chk("alarm early", alarm_relay, 1'b1);
    wait_for(2, 1'b0, 15);
    apb(1'b0, ba(`GBTRX_OFS_LIVE), 32'h0);
    chk("live block", rd[2], 1'b1);
    apb(1'b0, ba(`GBTRX_OFS_ISTAT), 32'h0);
    chk("alarm event", rd[`GBTRX_EV_ALARM], 1'b1);
    chk("masked irq", irq, 1'b0);
    apb(1'b0, ba(`GBTRX_OFS_CTRL), 32'h0);
    chk("ctrl reset", rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      h = (i == 0) ? 255 : ($random(seed) & 255);
      apb(1'b1, ba(`GBTRX_OFS_HOLD), 32'(h));
      apb(1'b0, ba(`GBTRX_OFS_HOLD), 32'h0);
      chk("hold value", rd, exp_hold(h));
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 8'h02, 32'h7);
    chk("misaligned err", err, 1'b1);
    apb(1'b1, ba(`GBTRX_OFS_IMASK), 32'h8);
    apb(1'b0, ba(`GBTRX_OFS_IMASK), 32'h0);
    chk("mask", rd, 32'h8);
    // Qualify guard against the latch left by reset
    mode <= 3'h1;
    tick(QUAL - 2);
    chk("latched block", block_relay, 1'b0);
    wait_for(1, 1'b1, 20);
    chk("guard lamp", guard_lamp, 1'b1);
    // Every pairing of configured and received level
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, ba(`GBTRX_OFS_CTRL), 32'(b << `GBTRX_CTRL_BOOST));
      for (int m = 0; m < 2; m++) begin
        boost <= m[0];
        mode  <= 3'h2;
        tick(10);
        chk("trip vs level", trip_out, 1'(b == m));
        chk("buffered trip", trip_buf, 1'(b == m));
        mode <= 3'h1;
        tick(10);
        chk("trip ends", trip_out, 1'b0);
      end
    end
    boost <= 1'b0;
    apb(1'b1, ba(`GBTRX_OFS_CTRL), 32'h0);
    mode <= 3'h3;
    tick(5);
    mode <= 3'h2;
    tick(10);
    chk("trip without guard", trip_out, 1'b0);
    mode <= 3'h1;
    tick(10);
    // Dead zone and each fault kind on a random channel
    foreach (fl[i]) begin
      fch  <= 1'($random(seed));
      mode <= fl[i];
      tick(8);
      chk("fault blocks", block_relay, 1'b0);
      chk("gain lamp", agc_lamp, 1'(fl[i][2:1] == 2'b11));
      mode <= 3'h1;
      wait_for(1, 1'b1, 12);
    end
    chk("gain irq", irq, 1'b1);
    apb(1'b0, ba(`GBTRX_OFS_ISTAT), 32'h0);
    chk("gain event", rd[`GBTRX_EV_AGC], 1'b1);
    tick(2);
    chk("irq cleared", irq, 1'b0);
    apb(1'b0, ba(`GBTRX_OFS_ISTAT), 32'h0);
    chk("read clears", rd[`GBTRX_EV_AGC], 1'b0);
    // Trip stretch by a random hold time
    h = 1 + ($random(seed) & 3);
    apb(1'b1, ba(`GBTRX_OFS_HOLD), 32'(h));
    apb(1'b1, ba(`GBTRX_OFS_CTRL), 32'h4);
    apb(1'b0, 8'h01, 32'h0);
    chk("misaligned data", rd, 32'h0);
    mode <= 3'h2;
    wait_for(0, 1'b1, 10);
    mode <= 3'h1;
    tick(h * MS + 2);
    chk("trip held", trip_out, 1'b1);
    wait_for(0, 1'b0, 12);
    // Permissive: later trips without guard unless invalid between
    apb(1'b1, ba(`GBTRX_OFS_CTRL), 32'h1);
    mode <= 3'h2;
    wait_for(0, 1'b1, 10);
    mode <= 3'h3;
    tick(6);
    chk("trip drops", trip_out, 1'b0);
    mode <= 3'h2;
    wait_for(0, 1'b1, 10);
    mode <= 3'h0;
    tick(6);
    mode <= 3'h2;
    tick(10);
    chk("invalid between trips", trip_out, 1'b0);
    mode <= 3'h1;
    tick(10);
    mode <= 3'h3;
    tick(5);
    mode <= 3'h2;
    wait_for(0, 1'b1, 10);
    // Long loss of signal latches the block
    apb(1'b1, ba(`GBTRX_OFS_CTRL), 32'h0);
    mode <= 3'h0;
    tick(QUAL + 10);
    mode <= 3'h1;
    tick(8);
    chk("latch holds", block_relay, 1'b0);
    mode <= 3'h2;
    tick(10);
    chk("stale guard", trip_out, 1'b0);
    mode <= 3'h1;
    tick(QUAL - 2);
    chk("latch before qual", block_relay, 1'b0);
    wait_for(1, 1'b1, 20);
    // A trip after a long guard gap is refused even in permissive mode
    apb(1'b1, ba(`GBTRX_OFS_CTRL), 32'h1);
    mode <= 3'h2;
    wait_for(0, 1'b1, 10);
    tick(QUAL);
    mode <= 3'h3;
    tick(5);
    mode <= 3'h2;
    tick(10);
    chk("late trip", trip_out, 1'b0);
    // Strict mode: a short guard does not lift the inhibit, a long one does
    apb(1'b1, ba(`GBTRX_OFS_CTRL), 32'h0);
    mode <= 3'h1;
    tick(8);
    mode <= 3'h2;
    tick(10);
    chk("inhibit kept", trip_out, 1'b0);
    mode <= 3'h1;
    tick(QUAL + 8);
    mode <= 3'h2;
    wait_for(0, 1'b1, 10);
    end_sim;
  end
endmodule // testbench

// File: gbtrx_top.sv
// Guard-before-trip receive logic with APB registers and interrupt
//
// Summary of operation
// - Window comparator crossing on either channel blocks
// - Negative discriminator means guard, positive trip
// - Discriminator dead zone is invalid and blocks
// - Gain-control limit blocks and lights status lamp
// - Guard needs A high, B low, all clean
// - Trip needs A low, B high, level matches
// - No trip unless guard came immediately before
// - Guard absent over 100 ms inhibits trip
// - Strict mode: inhibit clears after 100 ms guard
// - Abnormal 100 ms latches block until 100 ms guard
// - Block relay drops while block is active
// - Alarm relay drops after two seconds block
// - Permissive: later trips need no guard between
// - Permissive: guard restores full guard-before-trip (not here: permissive rules stay in force until ctrl_perm is cleared)
// - Optional hold stretches trip up to 250 ms
// - Trip drives isolated switch and buffer output
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps

`include "gbtrx_defines.svh"

module gbtrx_top
  import gbtrx_pkg::*;
#(
  parameter int unsigned CLK_HZ    = `GBTRX_CLK_HZ,
  parameter int unsigned MS_CYC    = (CLK_HZ + 999) / 1000,
  parameter int unsigned QUAL_CYC  = MS_CYC * `GBTRX_QUAL_MS,
  parameter int unsigned ALARM_CYC = MS_CYC * `GBTRX_ALARM_MS
) (
  input  wire logic              mclk,        // System clock, 40 MHz
  input  wire logic              rst_n,       // Asynchronous reset
  input  wire logic              psel,        // APB select
  input  wire logic              penable,     // APB access phase
  input  wire logic              pwrite,      // APB write
  input  wire logic [7:0]        paddr,       // APB byte address
  input  wire logic [31:0]       pwdata,      // APB write data
  output logic                   pready,      // APB ready
  output logic      [31:0]       prdata,      // APB read data
  output logic                   pslverr,     // APB error, unmapped
  input  wire gbtrx_chan_s [1:0] ch_in,       // 0 lower A, 1 upper B
  output logic                   trip_out,    // Isolated trip switch
  output logic                   trip_buf,    // Buffered trip output
  output logic                   block_relay, // High while energised
  output logic                   alarm_relay, // High while energised
  output logic                   agc_lamp,    // Gain out-of-limit lamp
  output logic                   guard_lamp,  // Guard state lamp
  output logic                   irq          // Level interrupt
);

  localparam logic [31:0] MS_L    = 32'(MS_CYC);
  localparam logic [31:0] QUAL_L  = 32'(QUAL_CYC);
  localparam logic [31:0] GONE_L  = 32'(QUAL_CYC + 1);
  localparam logic [31:0] ALARM_L = 32'(ALARM_CYC);

  // Refuse timings the counters cannot express
  if (MS_CYC == 0 || QUAL_CYC < 2 || ALARM_CYC < QUAL_CYC) begin : g_bad
    $error("gbtrx_top: timing parameters out of range");
  end

  // Decoding used for both channels
  function automatic logic dead_zone(input gbtrx_chan_s c);
    return !(c.guard ^ c.trip);
  endfunction

  function automatic logic win_bad(input gbtrx_chan_s c);
    return c.win_hi | c.win_lo;
  endfunction

  function automatic logic agc_bad(input gbtrx_chan_s c);
    return c.agc_hi | c.agc_lo;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a[7:2] <= `GBTRX_OFS_IMASK);
  endfunction

  gbtrx_chan_s ch [2];

  // Three-stage synchronisers; a change counts once stages two and three
  // agree, so a single metastable sample never reaches the decision logic
  for (genvar g = 0; g < 2; g++) begin : g_sync
    gbtrx_chan_s s1;
    gbtrx_chan_s s2;
    gbtrx_chan_s s3;
    gbtrx_chan_s q;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        s1 <= '0;
        s2 <= '0;
        s3 <= '0;
        q  <= '0;
      end else begin
        s1 <= ch_in[g];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          q <= s3;
        end
      end
    end
    assign ch[g] = q;
  end

  // Software settings
  logic [2:0]  ctrl;
  logic [7:0]  hold_ms;
  logic [3:0]  imask;
  logic [3:0]  istat;
  wire         ctrl_perm  = ctrl[`GBTRX_CTRL_PERM];
  wire         ctrl_boost = ctrl[`GBTRX_CTRL_BOOST];
  wire         ctrl_hold  = ctrl[`GBTRX_CTRL_HOLD_EN];

  // Decision state
  logic        block_latch;
  logic        inhibit;
  logic        armed;
  logic        trip_d;
  logic [31:0] guard_cnt;
  logic [31:0] gone_cnt;
  logic [31:0] abn_cnt;
  logic [31:0] blk_cnt;
  logic [31:0] hold_cnt;

  // Per-channel indications: guard on negative, trip on positive sense
  wire dead_any = dead_zone(ch[0]) | dead_zone(ch[1]);
  wire win_any  = win_bad(ch[0]) | win_bad(ch[1]);
  wire agc_any  = agc_bad(ch[0]) | agc_bad(ch[1]);
  wire clean    = !win_any && !agc_any;

  // Guard: lower channel at its high tone, upper at its low tone
  wire guard_st = ch[0].guard && !ch[0].trip &&
                  ch[1].guard && !ch[1].trip && clean;
  // Trip: the opposite pair, and the level as set up for boost
  wire lvl_ok   = (ch[0].boosted == ctrl_boost) &&
                  (ch[1].boosted == ctrl_boost);
  wire trip_st  = ch[0].trip && !ch[0].guard &&
                  ch[1].trip && !ch[1].guard &&
                  clean && lvl_ok;

  // Anything else, such as a crossed pair of tones, is abnormal
  wire abnormal   = !guard_st && !trip_st;
  wire blk_now    = win_any || dead_any || agc_any;
  wire block_cond = blk_now || block_latch;

  // Qualification timers
  wire guard_q   = guard_cnt >= QUAL_L;
  wire guard_lost = gone_cnt >= GONE_L;
  wire abn_q     = abn_cnt >= QUAL_L;
  wire alarm_hit = block_cond && (blk_cnt >= ALARM_L);

  // Trip that starts after a long guard gap is inhibited at once, so
  // the set term also gates this cycle's acceptance
  wire trip_new  = trip_st && !trip_d;
  wire inh_set   = trip_new && guard_lost;
  // Permissive mode lifts the inhibit on any guard
  wire inh_rel   = ctrl_perm ? guard_st : guard_q;
  // Permissive mode only disarms on a truly invalid signal
  wire disarm    = ctrl_perm ? blk_now : abnormal;

  wire trip_ok   = trip_st && armed && !inhibit && !inh_set &&
                   !block_latch;

  wire next_block_latch = abn_q || (block_latch && !guard_q);
  wire next_inhibit     = inh_set || (inhibit && !inh_rel);
  wire next_armed       = guard_st || (armed && !disarm);
  wire hold_act         = ctrl_hold && (hold_cnt != 32'h0000_0000);
  wire next_trip_out    = trip_ok || hold_act;
  wire [31:0] hold_load = ctrl_hold ? 32'(hold_ms) * MS_L : 32'h0000_0000;

  // Saturating interval counters
  wire [31:0] next_guard_cnt = !guard_st ? 32'h0000_0000 :
                               guard_q ? guard_cnt : guard_cnt + 32'h1;
  wire [31:0] next_gone_cnt  = guard_st ? 32'h0000_0000 :
                               guard_lost ? gone_cnt : gone_cnt + 32'h1;
  wire [31:0] next_abn_cnt   = !abnormal ? 32'h0000_0000 :
                               abn_q ? abn_cnt : abn_cnt + 32'h1;
  wire [31:0] next_blk_cnt   = !block_cond ? 32'h0000_0000 :
                               alarm_hit ? blk_cnt : blk_cnt + 32'h1;
  // Hold reloads while the trip is accepted and runs down afterwards
  wire [31:0] next_hold_cnt  = trip_ok ? hold_load :
                               (hold_cnt == 32'h0000_0000) ? hold_cnt :
                               hold_cnt - 32'h1;

  // Timers; reset leaves the link blocked until guard qualifies
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      guard_cnt <= 32'h0000_0000;
      gone_cnt  <= 32'h0000_0000;
      abn_cnt   <= 32'h0000_0000;
      blk_cnt   <= 32'h0000_0000;
      hold_cnt  <= 32'h0000_0000;
    end else begin
      guard_cnt <= next_guard_cnt;
      gone_cnt  <= next_gone_cnt;
      abn_cnt   <= next_abn_cnt;
      blk_cnt   <= next_blk_cnt;
      hold_cnt  <= next_hold_cnt;
    end
  end

  // Decision registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      block_latch <= 1'b1;
      inhibit     <= 1'b0;
      armed       <= 1'b0;
      trip_d      <= 1'b0;
    end else begin
      block_latch <= next_block_latch;
      inhibit     <= next_inhibit;
      armed       <= next_armed;
      trip_d      <= trip_st;
    end
  end

  // Relay and lamp outputs; relays are energised when high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trip_out    <= 1'b0;
      trip_buf    <= 1'b0;
      block_relay <= 1'b0;
      alarm_relay <= 1'b1;
      agc_lamp    <= 1'b0;
      guard_lamp  <= 1'b0;
    end else begin
      trip_out    <= next_trip_out;
      trip_buf    <= next_trip_out;
      block_relay <= !block_cond;
      alarm_relay <= !alarm_hit;
      agc_lamp    <= agc_any;
      guard_lamp  <= guard_st;
    end
  end

  // Events are edges of the registered outputs
  wire [3:0] ev;
  assign ev[`GBTRX_EV_TRIP]  = next_trip_out && !trip_out;
  assign ev[`GBTRX_EV_BLOCK] = block_cond && block_relay;
  assign ev[`GBTRX_EV_ALARM] = alarm_hit && alarm_relay;
  assign ev[`GBTRX_EV_AGC]   = agc_any && !agc_lamp;

  // APB decode; every access answers in its first access cycle
  wire       setup   = psel && !penable;
  wire       acc     = psel && penable && pready;
  wire [5:0] widx    = paddr[7:2];
  wire       wr      = acc && pwrite && is_mapped(paddr);
  wire       rd_stat = acc && !pwrite && is_mapped(paddr) &&
                       (widx == `GBTRX_OFS_ISTAT);

  gbtrx_live_s live;
  assign live = '{agc_lamp: agc_lamp, alarm: !alarm_relay,
                  trip_out: trip_out, armed: armed, inhibit: inhibit,
                  latch: block_latch, block: block_cond,
                  trip_st: trip_st, guard_st: guard_st};

  // Read mux; reserved bits read as zero
  wire [31:0] rdata =
    (widx == `GBTRX_OFS_CTRL)  ? {29'h0, ctrl}    :
    (widx == `GBTRX_OFS_HOLD)  ? {24'h0, hold_ms} :
    (widx == `GBTRX_OFS_LIVE)  ? {23'h0, live}    :
    (widx == `GBTRX_OFS_ISTAT) ? {28'h0, istat}   :
    (widx == `GBTRX_OFS_IMASK) ? {28'h0, imask}   : 32'h0000_0000;

  // Clearing only the bits that were actually returned keeps an event
  // that lands between setup and access from being lost; a new event
  // in the clearing cycle itself wins over the clear
  wire [3:0] stat_clr   = rd_stat ? prdata[3:0] : 4'h0;
  wire [3:0] next_istat = (istat & ~stat_clr) | ev;
  wire [7:0] wr_hold    = (pwdata[7:0] > `GBTRX_HOLD_MAX_MS) ?
                          `GBTRX_HOLD_MAX_MS : pwdata[7:0];

  // APB answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !is_mapped(paddr);
      if (setup && !pwrite) begin
        prdata <= is_mapped(paddr) ? rdata : 32'h0000_0000;
      end
    end
  end

  // Software registers and interrupt
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= `GBTRX_CTRL_RST;
      hold_ms <= `GBTRX_HOLD_RST;
      imask   <= `GBTRX_IMASK_RST;
      istat   <= 4'h0;
      irq     <= 1'b0;
    end else begin
      if (wr && widx == `GBTRX_OFS_CTRL) begin
        ctrl <= pwdata[2:0];
      end
      if (wr && widx == `GBTRX_OFS_HOLD) begin
        hold_ms <= wr_hold;
      end
      if (wr && widx == `GBTRX_OFS_IMASK) begin
        imask <= pwdata[3:0];
      end
      istat <= next_istat;
      irq   <= |(next_istat & imask);
    end
  end

  // Checks on the decision logic
  property p_block_relay;
    @(posedge mclk) disable iff (!rst_n)
      block_cond |=> !block_relay;
  endproperty
  a_block_relay: assert property (p_block_relay)
    else $error("block relay energised during block");

  property p_window;
    @(posedge mclk) disable iff (!rst_n)
      win_any |-> !trip_ok ##1 !block_relay;
  endproperty
  a_window: assert property (p_window)
    else $error("window crossing did not block");

  property p_dead;
    @(posedge mclk) disable iff (!rst_n)
      dead_any |-> !guard_st && !trip_st ##1 !block_relay;
  endproperty
  a_dead: assert property (p_dead)
    else $error("dead zone not treated as block");

  property p_agc;
    @(posedge mclk) disable iff (!rst_n)
      agc_any |=> agc_lamp && !block_relay;
  endproperty
  a_agc: assert property (p_agc)
    else $error("gain limit did not light lamp and block");

  property p_alarm;
    @(posedge mclk) disable iff (!rst_n)
      $fell(alarm_relay) |-> !block_relay && !$past(block_relay);
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm dropped without standing block");

  property p_trip_cause;
    @(posedge mclk) disable iff (!rst_n)
      $rose(trip_out) |-> $past(trip_st) && $past(armed) &&
                          !$past(block_latch);
  endproperty
  a_trip_cause: assert property (p_trip_cause)
    else $error("trip without preceding guard");

  property p_inhibit;
    @(posedge mclk) disable iff (!rst_n)
      inh_set |-> !trip_ok ##1 inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("late trip was not inhibited");

  property p_strict_release;
    @(posedge mclk) disable iff (!rst_n)
      $fell(inhibit) && !$past(ctrl_perm) |-> $past(guard_q);
  endproperty
  a_strict_release: assert property (p_strict_release)
    else $error("inhibit released before qualified guard");

  property p_latch;
    @(posedge mclk) disable iff (!rst_n)
      abn_q |=> block_latch;
  endproperty
  a_latch: assert property (p_latch)
    else $error("persistent abnormal did not latch block");

  property p_outputs_pair;
    @(posedge mclk) disable iff (!rst_n)
      trip_out == trip_buf;
  endproperty
  a_outputs_pair: assert property (p_outputs_pair)
    else $error("trip outputs disagree");

  property p_reset_state;
    @(posedge mclk) disable iff (!rst_n)
      !$past(rst_n) |-> !trip_out && !block_relay;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset did not start blocked");

endmodule // gbtrx_top
